// File: shared/psram_seq_pkg.sv
// Constants used by the burst bus sequencer except SYNC_RESET and SYNC_STAGES; its pin synchroniser uses none of them
package psram_seq_pkg;

	// Initial read latency in clocks is the code plus an offset per mode
	localparam logic [4:0] FIXED_LAT_ADD = 5'h01;
	localparam logic [4:0] VAR_LAT_ADD = 5'h02;
	// A refresh collision stretches variable latency by this factor
	localparam int REFRESH_LAT_MULT = 2;

	// Reset values
	localparam logic [15:0] DQ_RESET = 16'h0000;
	localparam logic [4:0] LAT_RESET = 5'h00;
	localparam logic [1:0] SYNC_RESET = 2'h0;

	// Depth of the pin synchroniser
	localparam int SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LATENCY,
		ST_DATA,
		ST_ROW_END
	} seq_state_t;

endpackage : psram_seq_pkg

// File: rtl/pin_sync.sv
// Two-flop synchroniser for a group of pins sampled by ref_clk
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Pins
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync_out
);

	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage2_q;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			stage1_q <= RESET_VAL;
			stage2_q <= RESET_VAL;
		end else begin
			stage1_q <= pin_in;
			stage2_q <= stage1_q;
		end
	end

	assign pin_sync_out = stage2_q;

endmodule : pin_sync

`default_nettype wire

// File: rtl/burst_psram_bus_sequencing.sv
// Burst bus sequencer of a pseudo-static memory: latency, WAIT, data phase
`timescale 1ns/1ps
`default_nettype none

module burst_psram_bus_sequencing #(
	parameter int ADDR_W = 21,
	parameter int ROW_BITS = 7
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Burst bus pins from the controller
	input wire logic bus_clk,
	input wire logic chip_sel_n,
	input wire logic address_valid_n,
	input wire logic out_en_n,
	input wire logic write_en_n,
	input wire logic lower_byte_sel_n,
	input wire logic upper_byte_sel_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [15:0] dq_in,
	// Burst bus pins to the controller
	output logic [15:0] dq_out,
	output logic dq_oe,
	output logic wait_out,
	output logic wait_oe,
	// Configuration bits of bus_config_reg
	input wire logic [2:0] latency_count,
	input wire logic fixed_latency,
	input wire logic wait_active_high,
	input wire logic burst_wrap,
	// Internal refresh engine, same clock
	input wire logic refresh_busy,
	// Memory array port, same clock
	output logic [ADDR_W-1:0] mem_addr,
	output logic mem_wr,
	output logic [15:0] mem_wdata,
	output logic [1:0] mem_be,
	input wire logic [15:0] mem_rdata
);

	localparam int PIN_W = 7 + ADDR_W + 16;

	typedef struct packed {
		psram_seq_pkg::seq_state_t state;
		logic is_read;
		logic [4:0] lat_cnt;
		logic clk_prev;
		logic [ADDR_W-1:0] addr;
		logic [15:0] dq;
		logic wr;
		logic [15:0] wdata;
		logic [1:0] be;
		logic [4:0] lat_loaded;
	} seq_t;

	seq_t s_q;
	seq_t s_d;

	logic [PIN_W-1:0] pins_raw;
	logic [PIN_W-1:0] pins_s;
	logic clk_s;
	logic cs_n_s;
	logic adv_n_s;
	logic oe_n_s;
	logic we_n_s;
	logic lb_n_s;
	logic ub_n_s;
	logic [ADDR_W-1:0] addr_s;
	logic [15:0] dq_s;
	logic clk_rise;
	logic start;
	logic [4:0] lat_base;
	logic [4:0] lat_sel;
	logic row_last;
	logic wait_act;

	assign pins_raw = {bus_clk, chip_sel_n, address_valid_n, out_en_n,
		write_en_n, lower_byte_sel_n, upper_byte_sel_n, addr, dq_in};

	// Bus clock idles low, strobes idle high
	pin_sync #(
		.WIDTH(PIN_W),
		.RESET_VAL({1'b0, 6'h3F, {(ADDR_W + 16){1'b0}}})
	) u_pin_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.pin_in(pins_raw),
		.pin_sync_out(pins_s)
	);

	assign {clk_s, cs_n_s, adv_n_s, oe_n_s, we_n_s, lb_n_s, ub_n_s,
		addr_s, dq_s} = pins_s;

	// A stopped bus clock gives no rise, so a suspended burst just halts
	assign clk_rise = clk_s && !s_q.clk_prev;
	// Any clocked address-valid with select low opens a burst, even
	// mid-burst or straight after an asynchronous write
	assign start = clk_rise && !cs_n_s && !adv_n_s;

	localparam logic [4:0] LAT_ZERO = 5'h00;

	always_comb begin
		lat_base = {2'h0, latency_count} + psram_seq_pkg::VAR_LAT_ADD;
		if (!we_n_s) begin
			lat_sel = {2'h0, latency_count};
		end else if (fixed_latency) begin
			lat_sel = {2'h0, latency_count} + psram_seq_pkg::FIXED_LAT_ADD;
		end else begin
			lat_sel = refresh_busy ?
				5'(lat_base * psram_seq_pkg::REFRESH_LAT_MULT) : lat_base;
		end
	end

	assign row_last = &s_q.addr[ROW_BITS-1:0];

	always_comb begin
		s_d = s_q;
		s_d.clk_prev = clk_s;
		s_d.wr = 1'b0;
		// Write address advances a cycle late so it stands with mem_wr
		if (s_q.wr) begin
			s_d.addr = s_q.addr + ADDR_W'(1);
		end
		if (cs_n_s) begin
			s_d.state = psram_seq_pkg::ST_IDLE;
		end else if (start) begin
			s_d.is_read = we_n_s;
			s_d.addr = addr_s;
			s_d.lat_cnt = lat_sel;
			s_d.lat_loaded = lat_sel;
			s_d.state = (lat_sel == LAT_ZERO) ?
				psram_seq_pkg::ST_DATA : psram_seq_pkg::ST_LATENCY;
		end else if (clk_rise) begin
			case (s_q.state)
				psram_seq_pkg::ST_LATENCY: begin
					s_d.lat_cnt = s_q.lat_cnt - 5'h01;
					if (s_q.lat_cnt == 5'h01) begin
						s_d.state = psram_seq_pkg::ST_DATA;
					end
				end
				psram_seq_pkg::ST_DATA: begin
					if (s_q.is_read) begin
						s_d.dq = mem_rdata;
						s_d.addr = s_q.addr + ADDR_W'(1);
					end else begin
						s_d.wr = 1'b1;
						s_d.wdata = dq_s;
						s_d.be = {!ub_n_s, !lb_n_s};
					end
					if (!burst_wrap && row_last) begin
						s_d.state = psram_seq_pkg::ST_ROW_END;
					end
				end
				psram_seq_pkg::ST_ROW_END: begin
					s_d.state = psram_seq_pkg::ST_ROW_END;
				end
				default: begin
					s_d.state = psram_seq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '{state: psram_seq_pkg::ST_IDLE, is_read: 1'b0,
				lat_cnt: psram_seq_pkg::LAT_RESET, clk_prev: 1'b0,
				addr: '0, dq: psram_seq_pkg::DQ_RESET, wr: 1'b0,
				wdata: psram_seq_pkg::DQ_RESET, be: 2'h0,
				lat_loaded: psram_seq_pkg::LAT_RESET};
		end else begin
			s_q <= s_d;
		end
	end

	// WAIT stays asserted through latency and at a row boundary
	assign wait_act = (s_q.state == psram_seq_pkg::ST_LATENCY) ||
		(s_q.state == psram_seq_pkg::ST_ROW_END);
	assign wait_out = wait_active_high ? wait_act : !wait_act;
	assign wait_oe = !cs_n_s;

	// Output data is a register, so a suspend leaves it driven and stable
	assign dq_out = s_q.dq;
	// The last word of a row is still driven while row-end WAIT holds
	assign dq_oe = !cs_n_s && !oe_n_s && s_q.is_read &&
		((s_q.state == psram_seq_pkg::ST_DATA) ||
		(s_q.state == psram_seq_pkg::ST_ROW_END));

	assign mem_addr = s_q.addr;
	assign mem_wr = s_q.wr;
	assign mem_wdata = s_q.wdata;
	assign mem_be = s_q.be;

	sequence rd_open_s;
		start && we_n_s;
	endsequence

	sequence wr_open_s;
		start && !we_n_s;
	endsequence

	a_fixed_rd_latency: assert property (@(posedge ref_clk) disable iff (!rst_b)
		rd_open_s and fixed_latency |=>
			s_q.lat_loaded == $past({2'h0, latency_count}) + 5'h01)
		else $error("fixed read latency is not code plus one");

	a_var_rd_latency: assert property (@(posedge ref_clk) disable iff (!rst_b)
		rd_open_s and !fixed_latency and !refresh_busy |=>
			s_q.lat_loaded == $past({2'h0, latency_count}) + 5'h02)
		else $error("variable read latency is not code plus two");

	a_refresh_double: assert property (@(posedge ref_clk) disable iff (!rst_b)
		rd_open_s and !fixed_latency and refresh_busy |=>
			s_q.lat_loaded == 5'(($past({2'h0, latency_count}) + 5'h02) * 2))
		else $error("refresh collision latency is not doubled");

	a_write_wait_len: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_open_s |=> s_q.lat_loaded == $past({2'h0, latency_count}))
		else $error("write wait length differs from latency code");

	a_wait_in_delay: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_q.state == psram_seq_pkg::ST_LATENCY |->
			wait_out == wait_active_high)
		else $error("wait not asserted during latency");

	a_wait_release: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_q.state == psram_seq_pkg::ST_LATENCY && s_q.lat_cnt == 5'h01 &&
		clk_rise && !cs_n_s && adv_n_s |=> wait_out != wait_active_high)
		else $error("wait held past the last latency clock");

	a_suspend_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
		dq_oe && !clk_rise ##1 dq_oe |-> $stable(dq_out))
		else $error("read data changed while bus clock stopped");

	a_suspend_drive: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_q.state == psram_seq_pkg::ST_DATA && s_q.is_read &&
		!cs_n_s && !oe_n_s |-> dq_oe)
		else $error("read data not driven with output enable low");

	a_select_kept: assert property (@(posedge ref_clk) disable iff (!rst_b)
		start && !cs_n_s |=> s_q.state != psram_seq_pkg::ST_IDLE)
		else $error("burst refused with select held low");

endmodule : burst_psram_bus_sequencing

`default_nettype wire

// File: sim/bus_ctl_model.sv
// Controller model that drives bursts onto the memory's bus pins
`timescale 1ns/1ps
`default_nettype none

module bus_ctl_model (
	// Clock
	input wire logic ref_clk,
	// Pins driven by the controller
	output logic bus_clk,
	output logic chip_sel_n,
	output logic address_valid_n,
	output logic out_en_n,
	output logic write_en_n,
	output logic [1:0] lane_n,
	output logic [20:0] addr,
	output logic [15:0] dq_in,
	// Pins seen from the memory, and its WAIT polarity setting
	input wire logic [15:0] dq_out,
	input wire logic dq_oe,
	input wire logic wait_out,
	input wire logic wait_oe,
	input wire logic wait_act
);
	// Bus clock idles low, select and strobes idle high
	initial {bus_clk, chip_sel_n, address_valid_n, out_en_n, write_en_n,
		lane_n, addr, dq_in} = {7'h3F, 37'h0};

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : idle

	// r rises follow the opening rise; n words; lat = r - n
	task automatic burst(input logic w, input logic [20:0] a, input int r,
		input int n, input int susp, input logic keep,
		input logic [17:0] wd [4],
		output int wc, output logic [15:0] rd [4]);
		int k;
		wc = 0;
		chip_sel_n <= 1'b0;
		address_valid_n <= 1'b0;
		write_en_n <= !w;
		addr <= a;
		idle(10);
		bus_clk <= 1'b1;
		idle(10);
		address_valid_n <= 1'b1;
		out_en_n <= w;
		for (int j = 1; j <= r + 1; j++) begin
			k = j - (r - n) - 1;
			bus_clk <= 1'b0;
			if (w && k >= 0 && k < n) {lane_n, dq_in} <= wd[k];
			else dq_in <= ~dq_in; // Released data never shows a stale word
			// Suspend holds the clock low, no rise at all
			idle(j == r - n + 2 ? susp + 10 : 10);
			if (wait_oe && wait_out === wait_act) wc++;
			// An undriven data bus reads back as the inverse word
			if (!w && k >= 1) rd[k - 1] = dq_oe ? dq_out : ~dq_out;
			if (j <= r) begin
				bus_clk <= 1'b1;
				idle(10);
			end
		end
		// Select goes high before any further rise, unless the next
		// burst is to follow with select held low
		chip_sel_n <= !keep;
		out_en_n <= 1'b1;
		idle(10);
	endtask : burst
endmodule : bus_ctl_model
`default_nettype wire

// File: sim/burst_psram_bus_sequencing_bench.sv
// Bench comparing the burst sequencer with a queue-based model
`timescale 1ns/1ps
`default_nettype none

module burst_psram_bus_sequencing_bench;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic bus_clk, chip_sel_n, address_valid_n, out_en_n, write_en_n;
	logic [1:0] lane_n;
	logic [20:0] addr, mem_addr;
	logic [15:0] dq_in, dq_out, mem_wdata, mem_rdata;
	logic dq_oe, wait_out, wait_oe, mem_wr;
	logic [1:0] mem_be;
	logic [2:0] latency_count = 3'h2;
	logic fixed_latency = 1'b0;
	logic wait_active_high = 1'b0;
	logic burst_wrap = 1'b1;
	logic refresh_busy = 1'b0;
	logic [38:0] exp_q [$];
	int failures = 0;
	int n_compared = 0;

	function automatic logic [15:0] pat(input logic [20:0] x);
		return x[15:0] ^ {x[20:16], 11'h2A5};
	endfunction : pat

	assign mem_rdata = pat(mem_addr);

	burst_psram_bus_sequencing dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
		.bus_clk(bus_clk), .chip_sel_n(chip_sel_n),
		.address_valid_n(address_valid_n), .out_en_n(out_en_n),
		.write_en_n(write_en_n), .lower_byte_sel_n(lane_n[0]),
		.upper_byte_sel_n(lane_n[1]), .addr(addr), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe), .wait_out(wait_out),
		.wait_oe(wait_oe), .latency_count(latency_count),
		.fixed_latency(fixed_latency), .wait_active_high(wait_active_high),
		.burst_wrap(burst_wrap), .refresh_busy(refresh_busy),
		.mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.mem_be(mem_be), .mem_rdata(mem_rdata));

	bus_ctl_model pm_u (.ref_clk(ref_clk), .bus_clk(bus_clk),
		.chip_sel_n(chip_sel_n), .address_valid_n(address_valid_n),
		.out_en_n(out_en_n), .write_en_n(write_en_n), .lane_n(lane_n),
		.addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.wait_out(wait_out), .wait_oe(wait_oe),
		.wait_act(wait_active_high));

	initial begin
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic check(input string nm, input logic [38:0] e,
		input logic [38:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : check

	task automatic close_out();
		$display("checks %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : close_out

	always @(posedge ref_clk) begin
		if (mem_wr === 1'b1) begin
			check("array write", exp_q.size() ? exp_q.pop_front() : '1,
				{mem_addr, mem_be, mem_wdata});
		end
	end

	task automatic run(input logic w, input logic [20:0] a, input int n,
		input int susp, input logic keep);
		logic [17:0] wd [4];
		logic [15:0] rd [4];
		int lat, wc, ex;
		lat = w ? latency_count : fixed_latency ? latency_count + 1 :
			(latency_count + 2) * (refresh_busy ? 2 : 1);
		ex = (!burst_wrap && a[6:0] + n == 128) ? 1 : 0;
		for (int k = 0; k < 4; k++) begin
			wd[k] = 18'($urandom);
			if (w && k < n) exp_q.push_back({a + 21'(k), ~wd[k][17:16],
				wd[k][15:0]});
		end
		pm_u.burst(w, a, lat + n, n, susp, keep, wd, wc, rd);
		check("wait rises", lat + ex, wc);
		for (int k = 0; k < n; k++) begin
			if (!w) check("read word", pat(a + 21'(k)), rd[k]);
		end
		check("writes left", 0, exp_q.size());
		check("wait enable", keep, wait_oe);
	endtask : run

	initial begin
		logic [20:0] a;
		void'($urandom(40));
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (5) @(posedge ref_clk);
		for (int t = 0; t < 24; t++) begin
			a = 21'($urandom);
			a[6] = 1'b0;
			latency_count <= 3'($urandom);
			fixed_latency <= 1'($urandom);
			refresh_busy <= 1'($urandom);
			wait_active_high <= 1'($urandom);
			@(posedge ref_clk);
			run(1'($urandom), a, 1 + $urandom % 4, 30 * ($urandom % 2),
				1'b0);
		end
		// A write followed with select held low by a read that cuts in
		run(1'b1, 21'h0A5A10, 3, 0, 1'b1);
		run(1'b0, 21'h0A5A10, 3, 30, 1'b0);
		// Row end with wrap off: device stops and raises WAIT
		burst_wrap <= 1'b0;
		@(posedge ref_clk);
		run(1'b0, 21'h00107E, 2, 0, 1'b0);
		run(1'b1, 21'h1FFF7E, 2, 0, 1'b0);
		close_out();
	end

	initial begin
		#160000;
		failures++;
		close_out();
	end
endmodule : burst_psram_bus_sequencing_bench
`default_nettype wire
